// >>> logic/cprb_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "cprb_map.svh"

module cprb_bank
  import cprb_pkg::*;
#(
  parameter logic [7:0] LARGE_UNIT_SIZE = 8'h03,
  parameter logic [6:0] CSD_CRC = 7'h00
)
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_rd_req,
  input wire logic [8:0] i_rd_index,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  input wire logic i_sw_valid,
  input wire cprb_sw_req_s i_sw_req,
  output logic o_sw_done,
  output logic o_sw_error,
  input wire logic i_blk_req,
  output logic [7:0] o_blk_data,
  output logic o_blk_valid,
  output logic o_blk_last,
  input wire logic i_sec_err_valid,
  input wire logic [7:0] i_sec_err_code,
  input wire logic i_fw_sector_ok,
  output logic [127:0] o_csd
);

  logic [7:0] modes_q [0:`CPRB_MODES_BYTES-1];
  logic [7:0] sec_err_q;
  logic [31:0] fw_cnt_q;
  cprb_state_e state_q;
  logic [8:0] blk_idx_q;
  logic sw_in_modes;

  // multi-byte fields are little endian, lowest index is the lsb
  function automatic logic [7:0] ext_byte(input logic [8:0] idx);
    logic [7:0] b;
    b = 8'h00;
    if (idx < 9'(`CPRB_MODES_BYTES))
      b = modes_q[idx[7:0]];
    else if (idx == `CPRB_OFS_SEC_ERR)
      b = sec_err_q;
    else if (idx == `CPRB_OFS_CMD_SETS)
      b = `CPRB_RST_CMD_SETS;
    else if (idx == `CPRB_OFS_PRIO_FEAT)
      b = `CPRB_RST_PRIO_FEAT;
    else if (idx == `CPRB_OFS_BKOPS)
      b = `CPRB_RST_BKOPS;
    else if (idx == `CPRB_OFS_PACK_RD || idx == `CPRB_OFS_PACK_WR)
      b = `CPRB_RST_PACKED;
    else if (idx == `CPRB_OFS_TAG_SUP)
      b = `CPRB_RST_TAG_SUP;
    else if (idx == `CPRB_OFS_TAG_UNIT)
      b = `CPRB_RST_TAG_UNIT;
    else if (idx == `CPRB_OFS_TAG_RES)
      b = `CPRB_RST_TAG_RES;
    else if (idx == `CPRB_OFS_CONTEXT)
      b = `CPRB_RST_CONTEXT;
    else if (idx == `CPRB_OFS_LARGE_UNIT)
      b = LARGE_UNIT_SIZE;
    else if (idx == `CPRB_OFS_ATTR_SUP)
      b = `CPRB_RST_ATTR_SUP;
    else if (idx == `CPRB_OFS_MODES_SUP)
      b = `CPRB_RST_MODES_SUP;
    else if (idx == `CPRB_OFS_FFU_FEAT)
      b = `CPRB_RST_FFU_FEAT;
    else if (idx == `CPRB_OFS_OPC_TMO)
      b = `CPRB_RST_OPC_TMO;
    else if (idx >= `CPRB_OFS_FIRMWARE_UPDATE_ARGUMENT && idx < `CPRB_OFS_OPC_TMO)
      b = 8'(`CPRB_RST_FIRMWARE_UPDATE_ARGUMENT >> (8 * (idx - `CPRB_OFS_FIRMWARE_UPDATE_ARGUMENT)));
    else if (idx >= `CPRB_OFS_FW_SECT && idx < `CPRB_OFS_FW_SECT + 9'h004)
      b = 8'(fw_cnt_q >> (8 * (idx - `CPRB_OFS_FW_SECT)));
    else if (idx >= `CPRB_OFS_HEALTH && idx <= `CPRB_OFS_HEALTH_END)
      b = 8'h00;
    else if (idx == `CPRB_OFS_LIFE_A || idx == `CPRB_OFS_LIFE_B)
      b = `CPRB_RST_LIFE;
    else if (idx == `CPRB_OFS_PRE_EOL)
      b = `CPRB_RST_PRE_EOL;
    return b;
  endfunction

  assign sw_in_modes = i_sw_req.index < 9'(`CPRB_MODES_BYTES);

  // switch requests only reach the modes segment
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (int i = 0; i < `CPRB_MODES_BYTES; i++)
        modes_q[i] <= 8'h00;
    end
    else if (i_sw_valid && sw_in_modes)
    begin
      case (i_sw_req.access)
        CPRB_SW_SET_BITS:
          modes_q[i_sw_req.index[7:0]] <=
            modes_q[i_sw_req.index[7:0]] | i_sw_req.value;
        CPRB_SW_CLR_BITS:
          modes_q[i_sw_req.index[7:0]] <=
            modes_q[i_sw_req.index[7:0]] & ~i_sw_req.value;
        CPRB_SW_WRITE:
          modes_q[i_sw_req.index[7:0]] <= i_sw_req.value;
        default:
          ;
      endcase
    end
  end

  // properties refuse every switch, and a command-set change is not kept
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_sw_done <= 1'b0;
      o_sw_error <= 1'b0;
    end
    else
    begin
      o_sw_done <= i_sw_valid;
      o_sw_error <= i_sw_valid &&
        (!sw_in_modes || i_sw_req.access == CPRB_SW_CMD_SET);
    end
  end

  // the first error code sticks until reset so it cannot be overwritten
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      sec_err_q <= `CPRB_RST_SEC_ERR;
    else if (i_sec_err_valid && sec_err_q == 8'h00)
      sec_err_q <= i_sec_err_code;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      fw_cnt_q <= `CPRB_RST_FW_SECT;
    else if (i_fw_sector_ok && fw_cnt_q != 32'hffffffff)
      fw_cnt_q <= fw_cnt_q + 32'h00000001;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_rd_data <= 8'h00;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_rd_valid <= i_rd_req;
      if (i_rd_req)
        o_rd_data <= ext_byte(i_rd_index);
    end
  end

  // a block request during a stream is ignored
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_q <= CPRB_IDLE;
      blk_idx_q <= 9'h000;
      o_blk_data <= 8'h00;
      o_blk_valid <= 1'b0;
      o_blk_last <= 1'b0;
    end
    else
    begin
      case (state_q)
        CPRB_IDLE:
        begin
          o_blk_valid <= 1'b0;
          o_blk_last <= 1'b0;
          if (i_blk_req)
          begin
            state_q <= CPRB_STREAM;
            blk_idx_q <= 9'h000;
          end
        end
        default:
        begin
          o_blk_valid <= 1'b1;
          o_blk_data <= ext_byte(blk_idx_q);
          o_blk_last <= blk_idx_q == `CPRB_LAST_INDEX;
          blk_idx_q <= blk_idx_q + 9'h001;
          if (blk_idx_q == `CPRB_LAST_INDEX)
            state_q <= CPRB_IDLE;
        end
      endcase
    end
  end

  // only the low card data fields live here; the upper ones read zero
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_csd <= 128'h0;
    else
    begin
      o_csd <= 128'h0;
      o_csd[`CPRB_CSD_WBL_HI:`CPRB_CSD_WBL_LO] <= `CPRB_CSD_WBL_VAL;
      o_csd[`CPRB_CSD_PARTIAL_BIT] <= `CPRB_CSD_PARTIAL_VAL;
      o_csd[`CPRB_CSD_CRC_HI:`CPRB_CSD_CRC_LO] <= CSD_CRC;
      o_csd[0] <= 1'b1;
    end
  end

  // helper state for the checks below
  logic seen_err_q;
  logic csd_up_q;
  logic [8:0] stream_cnt_q;
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      seen_err_q <= 1'b0;
      csd_up_q <= 1'b0;
      stream_cnt_q <= 9'h000;
    end
    else
    begin
      csd_up_q <= 1'b1;
      if (i_sec_err_valid)
        seen_err_q <= 1'b1;
      if (o_blk_valid)
        stream_cnt_q <= stream_cnt_q + 9'h001;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  a_block_length: assert property (
    o_blk_last |-> o_blk_valid && stream_cnt_q == `CPRB_LAST_INDEX)
    else $error("block last not on byte 511");

  a_block_whole: assert property (
    $rose(o_blk_valid) |-> o_blk_valid [*8] ##[1:510] o_blk_last)
    else $error("block stream broke early");

  a_props_locked: assert property (
    i_sw_valid && !sw_in_modes |=> o_sw_error && o_sw_done)
    else $error("switch to properties not refused");

  a_modes_write: assert property (
    i_sw_valid && sw_in_modes && i_sw_req.access == CPRB_SW_WRITE
    |=> modes_q[$past(i_sw_req.index[7:0])] == $past(i_sw_req.value)
        && !o_sw_error)
    else $error("switch write not applied");

  a_modes_clear: assert property (
    i_sw_valid && sw_in_modes && i_sw_req.access == CPRB_SW_CLR_BITS
    |=> (modes_q[$past(i_sw_req.index[7:0])] & $past(i_sw_req.value))
        == 8'h00)
    else $error("switch clear bits left set");

  a_write_len: assert property (
    csd_up_q |-> o_csd[25:22] == 4'h9)
    else $error("write block length code wrong");

  a_no_partial: assert property (
    csd_up_q |-> !o_csd[21])
    else $error("partial write bit set");

  a_csd_lsb: assert property (
    csd_up_q |-> o_csd[0])
    else $error("card data lsb not one");

  a_sec_clean: assert property (
    i_rd_req && i_rd_index == 9'h1f9 && !seen_err_q && !i_sec_err_valid
    |=> o_rd_valid && o_rd_data == 8'h00)
    else $error("security error byte not zero");

  a_packed_max: assert property (
    i_rd_req && (i_rd_index == 9'h1f4 || i_rd_index == 9'h1f5)
    |=> o_rd_data == 8'h3c)
    else $error("packed command limit wrong");

  a_attr_sup: assert property (
    i_rd_req && i_rd_index == 9'h1ee |=> o_rd_data == 8'h03)
    else $error("partition attribute support wrong");

  a_fw_count: assert property (
    i_rd_req && i_rd_index == 9'h12e |=> o_rd_data == $past(fw_cnt_q[7:0]))
    else $error("firmware sector count byte wrong");

  a_health_zero: assert property (
    i_rd_req && i_rd_index >= 9'h10e && i_rd_index <= 9'h12d
    |=> o_rd_data == 8'h00)
    else $error("health report not zero");

  a_life_est: assert property (
    i_rd_req && (i_rd_index == 9'h10c || i_rd_index == 9'h10d)
    |=> o_rd_data == 8'h01)
    else $error("lifetime estimate wrong");

  a_sw_answer: assert property (
    i_sw_valid |=> o_sw_done)
    else $error("switch request not answered");

  a_cmd_refused: assert property (
    i_sw_valid && i_sw_req.access == CPRB_SW_CMD_SET |=> o_sw_error)
    else $error("command set switch not refused");

  a_modes_set: assert property (
    i_sw_valid && sw_in_modes && i_sw_req.access == CPRB_SW_SET_BITS
    |=> (modes_q[$past(i_sw_req.index[7:0])] & $past(i_sw_req.value))
        == $past(i_sw_req.value))
    else $error("switch set bits not applied");

  a_rd_answer: assert property (
    i_rd_req |=> o_rd_valid)
    else $error("byte read not answered");

  a_rd_quiet: assert property (
    !i_rd_req |=> !o_rd_valid)
    else $error("read valid without request");

  a_sec_sticky: assert property (
    sec_err_q != 8'h00 |=> $stable(sec_err_q))
    else $error("security error code overwritten");

  a_blk_steady: assert property (
    o_blk_valid && !o_blk_last |=> o_blk_valid)
    else $error("block stream gap");

  c_block_read: cover property (o_blk_last);
  c_sw_write: cover property (
    i_sw_valid && sw_in_modes && i_sw_req.access == CPRB_SW_WRITE);
  c_sw_refused: cover property (o_sw_error);
  c_sec_error: cover property (i_sec_err_valid ##1 sec_err_q != 8'h00);

endmodule

`default_nettype wire

// >>> logic/cprb_map.svh
`ifndef CPRB_MAP_SVH
`define CPRB_MAP_SVH

`define CPRB_EXT_BYTES 512
`define CPRB_MODES_BYTES 192
`define CPRB_PROPS_BYTES 320
`define CPRB_LAST_INDEX 9'h1ff

`define CPRB_CSD_WBL_HI 25
`define CPRB_CSD_WBL_LO 22
`define CPRB_CSD_WBL_VAL 4'h9
`define CPRB_CSD_PARTIAL_BIT 21
`define CPRB_CSD_PARTIAL_VAL 1'h0
`define CPRB_CSD_CRC_HI 7
`define CPRB_CSD_CRC_LO 1

`define CPRB_OFS_SEC_ERR 9'h1f9
`define CPRB_OFS_CMD_SETS 9'h1f8
`define CPRB_OFS_PRIO_FEAT 9'h1f7
`define CPRB_OFS_BKOPS 9'h1f6
`define CPRB_OFS_PACK_RD 9'h1f5
`define CPRB_OFS_PACK_WR 9'h1f4
`define CPRB_OFS_TAG_SUP 9'h1f3
`define CPRB_OFS_TAG_UNIT 9'h1f2
`define CPRB_OFS_TAG_RES 9'h1f1
`define CPRB_OFS_CONTEXT 9'h1f0
`define CPRB_OFS_LARGE_UNIT 9'h1ef
`define CPRB_OFS_ATTR_SUP 9'h1ee
`define CPRB_OFS_MODES_SUP 9'h1ed
`define CPRB_OFS_FFU_FEAT 9'h1ec
`define CPRB_OFS_OPC_TMO 9'h1eb
`define CPRB_OFS_FIRMWARE_UPDATE_ARGUMENT 9'h1e7
`define CPRB_OFS_FW_SECT 9'h12e
`define CPRB_OFS_HEALTH 9'h10e
`define CPRB_OFS_HEALTH_END 9'h12d
`define CPRB_OFS_LIFE_B 9'h10d
`define CPRB_OFS_LIFE_A 9'h10c
`define CPRB_OFS_PRE_EOL 9'h10b

`define CPRB_RST_SEC_ERR 8'h00
`define CPRB_RST_CMD_SETS 8'h01
`define CPRB_RST_PRIO_FEAT 8'h01
`define CPRB_RST_BKOPS 8'h01
`define CPRB_RST_PACKED 8'h3c
`define CPRB_RST_TAG_SUP 8'h01
`define CPRB_RST_TAG_UNIT 8'h03
`define CPRB_RST_TAG_RES 8'h00
`define CPRB_RST_CONTEXT 8'h05
`define CPRB_RST_ATTR_SUP 8'h03
`define CPRB_RST_MODES_SUP 8'h01
`define CPRB_RST_FFU_FEAT 8'h00
`define CPRB_RST_OPC_TMO 8'h00
`define CPRB_RST_FIRMWARE_UPDATE_ARGUMENT 32'h0000ffff
`define CPRB_RST_FW_SECT 32'h00000000
`define CPRB_RST_LIFE 8'h01
`define CPRB_RST_PRE_EOL 8'h01

`endif

// >>> logic/cprb_pkg.sv
`default_nettype none
package cprb_pkg;
  typedef enum logic [1:0] {
    CPRB_SW_CMD_SET,
    CPRB_SW_SET_BITS,
    CPRB_SW_CLR_BITS,
    CPRB_SW_WRITE
  } cprb_access_e;

  typedef struct packed {
    cprb_access_e access;
    logic [8:0] index;
    logic [7:0] value;
  } cprb_sw_req_s;

  typedef enum logic {CPRB_IDLE, CPRB_STREAM} cprb_state_e;
endpackage
`default_nettype wire

// >>> verification/cprb_host.sv
`timescale 1ns/1ps
`default_nettype none
// host side: drives at falling edges and notes what it expects back
module cprb_host
  import cprb_pkg::*;
(
  input wire logic i_clk,
  output logic o_rd_req,
  output logic [8:0] o_rd_index,
  output logic o_sw_valid,
  output cprb_sw_req_s o_sw_req,
  output logic o_blk_req
);
  logic [7:0] rd_q[$];
  logic sw_q[$];
  initial
  begin
    o_rd_req = 1'b0;
    o_rd_index = 9'h000;
    o_sw_valid = 1'b0;
    o_sw_req = '0;
    o_blk_req = 1'b0;
  end
  // held high across calls so reads run back to back
  task automatic rd(input logic [8:0] idx, input logic [7:0] exp);
    @(negedge i_clk);
    o_rd_req = 1'b1;
    o_rd_index = idx;
    rd_q.push_back(exp);
  endtask
  // released index flips so a stale value never looks valid
  task automatic idle();
    @(negedge i_clk);
    o_rd_req = 1'b0;
    o_rd_index = ~o_rd_index;
  endtask
  // configuration is only ever touched through a switch
  task automatic sw(input cprb_access_e a, input logic [8:0] idx,
                    input logic [7:0] v, input logic err);
    @(negedge i_clk);
    o_rd_req = 1'b0;
    o_sw_valid = 1'b1;
    o_sw_req = '{a, idx, v};
    sw_q.push_back(err);
    @(negedge i_clk);
    o_sw_valid = 1'b0;
    o_sw_req = '{a, ~idx, ~v};
  endtask
  task automatic blk();
    @(negedge i_clk);
    o_rd_req = 1'b0;
    o_blk_req = 1'b1;
    @(negedge i_clk);
    o_blk_req = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> verification/test_cprb_bank.sv
`timescale 1ns/1ps
`default_nettype none
module test_cprb_bank
  import cprb_pkg::*;
;
  logic i_clk, i_resetn, rd_req, sw_valid, blk_req;
  logic [8:0] rd_index;
  cprb_sw_req_s sw_req;
  logic [7:0] o_rd_data, o_blk_data, m, seed;
  logic o_rd_valid, o_sw_done, o_sw_error, o_blk_valid, o_blk_last;
  logic i_sec_err_valid, i_fw_sector_ok;
  logic [7:0] i_sec_err_code;
  logic [127:0] o_csd;
  int failures = 0;
  int checks = 0;
  int bk = 0;
  logic [8:0] ix [12] = '{9'h1f9, 9'h1f5, 9'h1f4, 9'h1ee, 9'h12e,
    9'h131, 9'h10e, 9'h12d, 9'h10c, 9'h10d, 9'h1ff, 9'h1e7};
  logic [7:0] ev [12] = '{8'h00, 8'h3c, 8'h3c, 8'h03, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'hff};

  cprb_host u_cprb_host (.i_clk(i_clk), .o_rd_req(rd_req),
    .o_rd_index(rd_index), .o_sw_valid(sw_valid), .o_sw_req(sw_req),
    .o_blk_req(blk_req));
  cprb_bank u_cprb_bank (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_rd_req(rd_req), .i_rd_index(rd_index), .o_rd_data(o_rd_data),
    .o_rd_valid(o_rd_valid), .i_sw_valid(sw_valid), .i_sw_req(sw_req),
    .o_sw_done(o_sw_done), .o_sw_error(o_sw_error), .i_blk_req(blk_req),
    .o_blk_data(o_blk_data), .o_blk_valid(o_blk_valid),
    .o_blk_last(o_blk_last), .i_sec_err_valid(i_sec_err_valid),
    .i_sec_err_code(i_sec_err_code), .i_fw_sector_ok(i_fw_sector_ok),
    .o_csd(o_csd));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic finish_test();
    if (failures == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // results are taken off the queues as they appear
  always @(negedge i_clk)
  begin
    if (o_rd_valid === 1'b1)
      chk(o_rd_data, u_cprb_host.rd_q.pop_front());
    if (o_sw_done === 1'b1)
      chk(o_sw_error, u_cprb_host.sw_q.pop_front());
    if (o_blk_valid === 1'b1)
    begin
      chk(o_blk_last, bk == 511);
      if (bk == 191)
        chk(o_blk_data, m);
      if (bk == 500)
        chk(o_blk_data, 8'h3c);
      if (bk == 302)
        chk(o_blk_data, 8'h03);
      bk++;
    end
  end

  // whole run needs well under 2000 cycles
  initial
  begin
    repeat (4000) @(posedge i_clk);
    failures++;
    finish_test();
  end

  initial
  begin
    i_resetn = 1'b0;
    i_sec_err_valid = 1'b0;
    i_sec_err_code = 8'h00;
    i_fw_sector_ok = 1'b0;
    seed = 8'h2d;
    m = 8'h00;
    repeat (16) @(negedge i_clk);
    i_resetn = 1'b1;
    @(negedge i_clk);
    chk(o_csd[25:22], 4'h9);
    chk(o_csd[21], 1'b0);
    chk(o_csd[0], 1'b1);
    for (int k = 0; k < 12; k++)
      u_cprb_host.rd(ix[k], ev[k]);
    seed = lfsr(seed);
    m = seed;
    u_cprb_host.sw(CPRB_SW_WRITE, 9'h0bf, m, 1'b0);
    seed = lfsr(seed);
    m = m | seed;
    u_cprb_host.sw(CPRB_SW_SET_BITS, 9'h0bf, seed, 1'b0);
    seed = lfsr(seed);
    m = m & ~seed;
    u_cprb_host.sw(CPRB_SW_CLR_BITS, 9'h0bf, seed, 1'b0);
    u_cprb_host.sw(CPRB_SW_CMD_SET, 9'h0bf, 8'h5a, 1'b1);
    u_cprb_host.sw(CPRB_SW_WRITE, 9'h1f4, 8'h00, 1'b1);
    u_cprb_host.sw(CPRB_SW_WRITE, 9'h0c0, 8'h11, 1'b1);
    u_cprb_host.rd(9'h0bf, m);
    u_cprb_host.rd(9'h1f4, 8'h3c);
    u_cprb_host.rd(9'h0c0, 8'h00);
    u_cprb_host.idle();
    // three sector pulses; only the first error code may stick
    i_fw_sector_ok = 1'b1;
    i_sec_err_valid = 1'b1;
    i_sec_err_code = 8'h07;
    repeat (2) @(negedge i_clk);
    i_sec_err_code = 8'h09;
    @(negedge i_clk);
    i_fw_sector_ok = 1'b0;
    i_sec_err_valid = 1'b0;
    u_cprb_host.rd(9'h1f9, 8'h07);
    u_cprb_host.rd(9'h12e, 8'h03);
    u_cprb_host.rd(9'h12f, 8'h00);
    u_cprb_host.blk();
    repeat (100) @(negedge i_clk);
    u_cprb_host.blk();
    repeat (430) @(negedge i_clk);
    chk(bk, 512);
    // a reset in mid-run must clear the modes and the sticky error
    i_resetn = 1'b0;
    repeat (2) @(negedge i_clk);
    i_resetn = 1'b1;
    u_cprb_host.rd(9'h0bf, 8'h00);
    u_cprb_host.rd(9'h1f9, 8'h00);
    u_cprb_host.rd(9'h12e, 8'h00);
    u_cprb_host.idle();
    repeat (2) @(negedge i_clk);
    chk(u_cprb_host.rd_q.size(), 0);
    chk(u_cprb_host.sw_q.size(), 0);
    finish_test();
  end
endmodule
`default_nettype wire
